//--- src/phy_event_flags_and_cable_length.sv
`timescale 1ns/10ps
`default_nettype none
// phy event flags, enables and cable length, behind an ahb-lite slave
module phy_event_flags_and_cable_length (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [phy_evt_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [phy_evt_pkg::DATA_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [phy_evt_pkg::DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // phy detector levels, asynchronous
  input wire phy_evt_pkg::evt_s events_in,
  // cable diagnostic result, same clock
  input wire logic [phy_evt_pkg::CBL_W-1:0] cable_len_in,
  input wire logic link_100tx_in,
  input wire logic cable_fault_in,
  // combined interrupt request
  output logic irq_out
);

  // address match against a register index
  function automatic logic reg_hit(
    input logic [phy_evt_pkg::ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    reg_hit = (addr == {idx[5:0], 2'b00});
  endfunction : reg_hit

  // synchronised event levels
  phy_evt_pkg::evt_s lvl; // filtered level
  phy_evt_pkg::evt_s lvl_d; // one cycle older

  // register state
  logic [15:0] flags; // sticky event flags
  logic [15:0] enables; // per-source enables
  logic [3:0] cable_est; // cable length estimate
  logic [11:0] cable_rsvd; // reserved cable bits, kept as written
  phy_evt_pkg::addr_phase_s ap; // pending data phase

  // next values
  logic [15:0] next_flags;
  logic [15:0] next_enables;
  logic [11:0] next_cable_rsvd;
  logic [3:0] next_cable_est;
  logic [31:0] next_hrdata;
  phy_evt_pkg::addr_phase_s next_ap;

  // synchroniser for all detector levels
  evt_sync #(
    .W(phy_evt_pkg::EVT_N)
  ) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in(events_in),
    .level_out(lvl)
  );

  // edge detection works on the filtered levels only
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lvl_d <= '0;
    end else begin
      lvl_d <= lvl;
    end
  end

  // rising edges of each level, falling edge of the link status level only
  wire phy_evt_pkg::evt_s rise = lvl & ~lvl_d;
  wire logic link_fall = lvl_d.link_status & ~lvl.link_status;

  // event vector at the flag positions
  logic [15:0] evt_vec;
  always_comb begin
    evt_vec = phy_evt_pkg::REG_ZERO;
    evt_vec[phy_evt_pkg::BIT_LINK_UP] = rise.link_status;
    evt_vec[phy_evt_pkg::BIT_WAKE] = rise.wake_event;
    evt_vec[phy_evt_pkg::BIT_ENERGY] = rise.energy_detected;
    evt_vec[phy_evt_pkg::BIT_AN_DONE] = rise.autoneg_done;
    evt_vec[phy_evt_pkg::BIT_RFAULT] = rise.remote_fault;
    evt_vec[phy_evt_pkg::BIT_LINK_DOWN] = link_fall;
    evt_vec[phy_evt_pkg::BIT_ACK] = rise.partner_ack;
    evt_vec[phy_evt_pkg::BIT_PD_FAULT] = rise.parallel_fault;
    evt_vec[phy_evt_pkg::BIT_PAGE] = rise.page_received;
  end

  // only enabled sources may latch a flag
  wire logic [15:0] set_vec = evt_vec & enables & phy_evt_pkg::EVT_MASK;

  // address phase decode
  wire logic trans_ok = (htrans_in == phy_evt_pkg::HTRANS_NONSEQ)
                      || (htrans_in == phy_evt_pkg::HTRANS_SEQ);
  wire logic take = hsel_in && hready_in && trans_ok;
  wire logic rd_take = take && !hwrite_in;
  wire logic wr_take = take && hwrite_in && (hsize_in == phy_evt_pkg::HSIZE_WORD);

  // data phase decode of a pending write
  wire logic wr_en = ap.wr && reg_hit(ap.addr, phy_evt_pkg::IDX_ENABLES);
  wire logic wr_clr = ap.wr && reg_hit(ap.addr, phy_evt_pkg::IDX_CLEAR);
  wire logic wr_cbl = ap.wr && reg_hit(ap.addr, phy_evt_pkg::IDX_CABLE);
  wire logic [15:0] wdat = hwdata_in[15:0];

  // address phase decode of a read
  wire logic hit_cbl = reg_hit(haddr_in, phy_evt_pkg::IDX_CABLE);
  wire logic hit_flags = reg_hit(haddr_in, phy_evt_pkg::IDX_FLAGS);
  wire logic hit_en = reg_hit(haddr_in, phy_evt_pkg::IDX_ENABLES);
  wire logic rd_flags = rd_take && hit_flags;

  // values seen by a read right behind a write, so it is never stale
  wire logic [15:0] en_fwd = wr_en ? (wdat & phy_evt_pkg::EVT_MASK) : enables;
  wire logic [15:0] clr_vec = wr_clr ? wdat : phy_evt_pkg::REG_ZERO;
  wire logic [15:0] flags_fwd = flags & ~clr_vec;
  wire logic [11:0] rsvd_fwd = wr_cbl ? wdat[phy_evt_pkg::RSVD_W-1:0] : cable_rsvd;

  // flags: read clears all, clear register clears some, set wins over both
  wire logic [15:0] rd_clr = rd_flags ? phy_evt_pkg::EVT_MASK : phy_evt_pkg::REG_ZERO;
  assign next_flags = ((flags_fwd & ~rd_clr) | set_vec) & phy_evt_pkg::EVT_MASK;

  // enables: only bits 1..9 are writable, the rest stay zero
  assign next_enables = en_fwd;

  // reserved cable bits are stored, software is expected to write 12'h800
  assign next_cable_rsvd = rsvd_fwd;

  // estimate is only valid on a fault-free 100base-tx link, else zero
  wire logic tx_ok = link_100tx_in && !cable_fault_in;
  assign next_cable_est = tx_ok ? cable_len_in : phy_evt_pkg::CBL_RST;

  // read data is captured at the end of the address phase
  logic [15:0] rd_reg;
  always_comb begin
    rd_reg = phy_evt_pkg::REG_ZERO;
    if (hit_cbl) begin
      rd_reg = {cable_est, rsvd_fwd};
    end else if (hit_flags) begin
      rd_reg = flags_fwd;
    end else if (hit_en) begin
      rd_reg = en_fwd;
    end else begin
      rd_reg = phy_evt_pkg::REG_ZERO; // unmapped and clear register read zero
    end
  end
  assign next_hrdata = rd_take ? {16'h0000, rd_reg} : hrdata_out;

  // pending data phase
  always_comb begin
    next_ap.rd = rd_take;
    next_ap.wr = wr_take;
    next_ap.addr = haddr_in;
  end

  // bus slave state; zero wait states, response always okay
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ap <= '0;
      hrdata_out <= phy_evt_pkg::WORD_ZERO;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      ap <= next_ap;
      hrdata_out <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // register file
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags <= phy_evt_pkg::REG_ZERO;
      enables <= phy_evt_pkg::REG_ZERO;
      cable_rsvd <= phy_evt_pkg::CBL_RSVD_RST;
      cable_est <= phy_evt_pkg::CBL_RST;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      cable_rsvd <= next_cable_rsvd;
      cable_est <= next_cable_est;
    end
  end

  // interrupt follows the same next values so it lines up with the flags
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_flags & next_enables);
    end
  end

  // interrupt matches enabled flags in every cycle
  a_irq_level: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    irq_out == |(flags & enables)
  ) else $error("irq does not match enabled flags");

  // an enabled event is latched on the next edge
  a_set_latch: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (set_vec != 16'h0000) |=> ((flags & $past(set_vec)) == $past(set_vec))
  ) else $error("enabled event not latched");

  // a masked source never raises a new flag
  a_mask_holds: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    1'b1 |=> ((flags & ~$past(flags) & ~$past(enables)) == 16'h0000)
  ) else $error("masked source raised a flag");

  // read of flags returns old value, then clears unless a new event lands
  a_read_clear: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (rd_flags && !wr_clr) |=> (hrdata_out[15:0] == $past(flags))
      && (flags == $past(set_vec))
  ) else $error("flag read did not return and clear");

  // flags stay once set when nothing clears them
  a_flag_sticky: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (!rd_flags && !wr_clr) |=> ((flags & $past(flags)) == $past(flags))
  ) else $error("flag dropped without a clear");

  // link rise and fall reach bits 9 and 4 when enabled
  a_link_up: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.link_status) && enables[phy_evt_pkg::BIT_LINK_UP])
      |=> flags[phy_evt_pkg::BIT_LINK_UP]
  ) else $error("link up not flagged");

  a_link_down: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($fell(lvl.link_status) && enables[phy_evt_pkg::BIT_LINK_DOWN])
      |=> flags[phy_evt_pkg::BIT_LINK_DOWN]
  ) else $error("link down not flagged");

  // reserved bits of flags and enables stay zero
  a_rsvd_zero: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ((flags | enables) & ~phy_evt_pkg::EVT_MASK) == 16'h0000
  ) else $error("reserved bit set");

  // no estimate unless the link is fault-free 100base-tx
  a_cable_gate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !(link_100tx_in && !cable_fault_in) |=> (cable_est == 4'h0)
  ) else $error("cable estimate shown on unsupported link");

  // enable write lands in one cycle with reserved bits dropped
  a_enable_write: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    wr_en |=> (enables == ($past(wdat) & phy_evt_pkg::EVT_MASK))
  ) else $error("enable write not applied");

  // page received reaches bit 1 when enabled
  a_page_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.page_received) && enables[phy_evt_pkg::BIT_PAGE])
      |=> flags[phy_evt_pkg::BIT_PAGE]
  ) else $error("page received not flagged");

  // parallel detection fault reaches bit 2 when enabled
  a_pd_fault_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.parallel_fault) && enables[phy_evt_pkg::BIT_PD_FAULT])
      |=> flags[phy_evt_pkg::BIT_PD_FAULT]
  ) else $error("parallel detection fault not flagged");

  // partner acknowledge reaches bit 3 when enabled
  a_ack_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.partner_ack) && enables[phy_evt_pkg::BIT_ACK])
      |=> flags[phy_evt_pkg::BIT_ACK]
  ) else $error("partner acknowledge not flagged");

  // remote fault reaches bit 5 when enabled
  a_rfault_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.remote_fault) && enables[phy_evt_pkg::BIT_RFAULT])
      |=> flags[phy_evt_pkg::BIT_RFAULT]
  ) else $error("remote fault not flagged");

  // auto-negotiation done reaches bit 6 when enabled
  a_an_done_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.autoneg_done) && enables[phy_evt_pkg::BIT_AN_DONE])
      |=> flags[phy_evt_pkg::BIT_AN_DONE]
  ) else $error("auto-negotiation done not flagged");

  // energy detected reaches bit 7 when enabled
  a_energy_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.energy_detected) && enables[phy_evt_pkg::BIT_ENERGY])
      |=> flags[phy_evt_pkg::BIT_ENERGY]
  ) else $error("energy detect not flagged");

  // wake event reaches bit 8 when enabled
  a_wake_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(lvl.wake_event) && enables[phy_evt_pkg::BIT_WAKE])
      |=> flags[phy_evt_pkg::BIT_WAKE]
  ) else $error("wake event not flagged");

  // no detector edge means no new flag, so glitches on the bus cannot set one
  a_no_spurious_flag: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (evt_vec == phy_evt_pkg::REG_ZERO)
      |=> ((flags & ~$past(flags)) == 16'h0000)
  ) else $error("flag set without an event");

  // a latched enabled flag raises the interrupt unless an enable write masks it
  a_irq_raise: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ((set_vec != phy_evt_pkg::REG_ZERO) && !wr_en) |=> irq_out
  ) else $error("enabled event did not raise irq");

  // enables move only on an enable write
  a_enable_hold: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !wr_en |=> (enables == $past(enables))
  ) else $error("enables changed without a write");

  // enable read data stands through its data phase
  a_enable_read: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (ap.rd && reg_hit(ap.addr, phy_evt_pkg::IDX_ENABLES))
      |-> (hrdata_out[phy_evt_pkg::REG_W-1:0] == enables)
  ) else $error("enable read data wrong");

  // reserved flag bits read back as zero
  a_flags_rsvd_read: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (ap.rd && reg_hit(ap.addr, phy_evt_pkg::IDX_FLAGS))
      |-> ((hrdata_out[phy_evt_pkg::REG_W-1:0] & ~phy_evt_pkg::EVT_MASK) == 16'h0000)
  ) else $error("reserved flag bit read as one");

  // cable read returns the estimate held at the address phase
  a_cable_read: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (ap.rd && reg_hit(ap.addr, phy_evt_pkg::IDX_CABLE))
      |-> (hrdata_out[phy_evt_pkg::CBL_LSB +: phy_evt_pkg::CBL_W] == $past(cable_est))
  ) else $error("cable read data wrong");

  // estimate follows the diagnostic result on a supported link
  a_cable_follow: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (link_100tx_in && !cable_fault_in) |=> (cable_est == $past(cable_len_in))
  ) else $error("cable estimate does not follow result");

  // written reserved cable bits are kept for read back
  a_rsvd_store: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    wr_cbl |=> (cable_rsvd == 12'($past(wdat)))
  ) else $error("reserved cable bits not stored");

endmodule : phy_event_flags_and_cable_length
`default_nettype wire

//--- src/phy_evt_pkg.sv
package phy_evt_pkg;

  // bus geometry
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;

  // register indexes; byte address is index times four
  localparam logic [7:0] IDX_CABLE = 8'h1c;
  localparam logic [7:0] IDX_FLAGS = 8'h1d;
  localparam logic [7:0] IDX_ENABLES = 8'h1e;
  localparam logic [7:0] IDX_CLEAR = 8'h20;

  // field layout
  localparam logic [15:0] EVT_MASK = 16'h03fe;
  localparam logic [15:0] REG_ZERO = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int CBL_LSB = 12;
  localparam int CBL_W = 4;
  localparam int RSVD_W = 12;
  localparam logic [3:0] CBL_RST = 4'h0;
  localparam logic [11:0] CBL_RSVD_RST = 12'h800;

  // flag bit positions
  localparam int BIT_PAGE = 1;
  localparam int BIT_PD_FAULT = 2;
  localparam int BIT_ACK = 3;
  localparam int BIT_LINK_DOWN = 4;
  localparam int BIT_RFAULT = 5;
  localparam int BIT_AN_DONE = 6;
  localparam int BIT_ENERGY = 7;
  localparam int BIT_WAKE = 8;
  localparam int BIT_LINK_UP = 9;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // raw event levels from the phy detectors
  typedef struct packed {
    logic link_status;
    logic wake_event;
    logic energy_detected;
    logic autoneg_done;
    logic remote_fault;
    logic partner_ack;
    logic parallel_fault;
    logic page_received;
  } evt_s;

  localparam int EVT_N = $bits(evt_s);

  // captured address phase
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
  } addr_phase_s;

endpackage : phy_evt_pkg

//--- src/evt_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser with agreement filter
module evt_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // asynchronous levels in, filtered levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1; // first stage, read only by s2
  logic [W-1:0] s2; // second stage
  logic [W-1:0] s3; // third stage

  // a bit changes only once stages two and three agree
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      level_out <= (s2 & s3) | (level_out & (s2 | s3));
    end
  end

endmodule : evt_sync
`default_nettype wire

//--- sim/phy_detector_model.sv
`timescale 1ns/10ps
`default_nettype none
// stands in for the phy detectors and the cable diagnostic engine
module phy_detector_model (
  // clock
  input wire logic mclk_in,
  // levels the bench wants the detectors to show
  input wire phy_evt_pkg::evt_s want_in,
  input wire logic [3:0] len_want_in,
  input wire logic tx_want_in,
  input wire logic fault_want_in,
  // detector levels toward the block
  output phy_evt_pkg::evt_s events_out,
  output logic [3:0] cable_len_out,
  output logic link_100tx_out,
  output logic cable_fault_out
);
  // cycles since the event levels last moved
  int unsigned age;

  initial begin
    age = 0;
    events_out = 8'h00;
    cable_len_out = 4'h0;
    link_100tx_out = 1'b0;
    cable_fault_out = 1'b0;
  end

  // a level moves only after standing four cycles, so the filter never drops it
  always @(posedge mclk_in) begin
    age <= age + 1;
    if (want_in !== events_out && age >= 4) begin
      events_out <= want_in;
      age <= 0;
    end
    // diagnostic result follows on the same clock
    cable_len_out <= len_want_in;
    link_100tx_out <= tx_want_in;
    cable_fault_out <= fault_want_in;
  end
endmodule : phy_detector_model
`default_nettype wire

//--- sim/phy_event_flags_and_cable_length_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the event flag block
module phy_event_flags_and_cable_length_tb_top;
  // byte addresses: index times four
  localparam logic [7:0] A_CBL = 8'h70;
  localparam logic [7:0] A_FLG = 8'h74;
  localparam logic [7:0] A_ENA = 8'h78;
  localparam logic [7:0] A_CLR = 8'h80;
  localparam logic [7:0] A_BAD = 8'h40;
  logic mclk_in;
  logic nrst_in;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  phy_evt_pkg::evt_s events;
  phy_evt_pkg::evt_s want;
  logic [3:0] cable_len;
  logic [3:0] len_want;
  logic link_100tx;
  logic cable_fault;
  logic tx_want;
  logic fault_want;
  int checks = 0;
  int miscompares = 0;

  phy_event_flags_and_cable_length u_phy_event_flags_and_cable_length (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .events_in(events), .cable_len_in(cable_len),
    .link_100tx_in(link_100tx), .cable_fault_in(cable_fault), .irq_out(irq));

  phy_detector_model u_phy_detector_model (
    .mclk_in(mclk_in), .want_in(want), .len_want_in(len_want),
    .tx_want_in(tx_want), .fault_want_in(fault_want), .events_out(events),
    .cable_len_out(cable_len), .link_100tx_out(link_100tx),
    .cable_fault_out(cable_fault));

  // 50 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // waits for hready at an edge; a stuck slave counts as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) miscompares++;
  endtask : wait_ready

  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= phy_evt_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= phy_evt_pkg::HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // flags expected after a full pulse of detector i; link makes up and down
  function automatic logic [31:0] flag_exp(input int i);
    case (i)
      0: return 32'h0000_0001 << phy_evt_pkg::BIT_PAGE;
      1: return 32'h0000_0001 << phy_evt_pkg::BIT_PD_FAULT;
      2: return 32'h0000_0001 << phy_evt_pkg::BIT_ACK;
      3: return 32'h0000_0001 << phy_evt_pkg::BIT_RFAULT;
      4: return 32'h0000_0001 << phy_evt_pkg::BIT_AN_DONE;
      5: return 32'h0000_0001 << phy_evt_pkg::BIT_ENERGY;
      6: return 32'h0000_0001 << phy_evt_pkg::BIT_WAKE;
      default: return 32'h0000_0210;
    endcase
  endfunction : flag_exp

  // raise then drop one detector level, leaving time to be filtered
  task automatic pulse(input int i);
    want[i] <= 1'b1;
    repeat (12) @(posedge mclk_in);
    want[i] <= 1'b0;
    repeat (12) @(posedge mclk_in);
  endtask : pulse

  task automatic t_reset();
    rd(A_CBL, 32'h0000_0800);
    rd(A_FLG, 32'h0000_0000);
    rd(A_ENA, 32'h0000_0000);
    rd(A_BAD, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enables();
    wr(A_ENA, 32'hffff_ffff);
    rd(A_ENA, 32'h0000_03fe);
    wr(A_FLG, 32'hffff_ffff);
    check({31'h0, hresp}, 32'h0000_0000);
    rd(A_FLG, 32'h0000_0000);
    wr(A_ENA, 32'h0000_0000);
    rd(A_ENA, 32'h0000_0000);
    $display("test enables done");
  endtask : t_enables

  // every detector in turn, all sources enabled
  task automatic t_events();
    wr(A_ENA, 32'h0000_03fe);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      check({31'h0, irq}, 32'h0000_0001);
      rd(A_FLG, flag_exp(i));
      check({31'h0, irq}, 32'h0000_0000);
      rd(A_FLG, 32'h0000_0000);
    end
    $display("test events done");
  endtask : t_events

  // only link up enabled: wake and link down must be lost
  task automatic t_masked();
    wr(A_ENA, 32'h0000_0200);
    pulse(6);
    check({31'h0, irq}, 32'h0000_0000);
    pulse(7);
    rd(A_FLG, 32'h0000_0200);
    $display("test masked done");
  endtask : t_masked

  task automatic t_cable();
    len_want <= 4'ha;
    tx_want <= 1'b1;
    repeat (4) @(posedge mclk_in);
    wr(A_CBL, 32'h0000_f800);
    rd(A_CBL, 32'h0000_a800);
    fault_want <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rd(A_CBL, 32'h0000_0800);
    fault_want <= 1'b0;
    tx_want <= 1'b0;
    repeat (4) @(posedge mclk_in);
    rd(A_CBL, 32'h0000_0800);
    $display("test cable done");
  endtask : t_cable

  // clear register drops only the bits written as one
  task automatic t_clear();
    wr(A_ENA, 32'h0000_03fe);
    pulse(0);
    pulse(1);
    wr(A_CLR, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0001);
    rd(A_FLG, 32'h0000_0004);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test clear done");
  endtask : t_clear

  // reset in mid-run drops flags, enables and the interrupt at once
  task automatic t_midreset();
    pulse(0);
    check({31'h0, irq}, 32'h0000_0001);
    nrst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check({31'h0, irq}, 32'h0000_0000);
    nrst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rd(A_ENA, 32'h0000_0000);
    rd(A_FLG, 32'h0000_0000);
    rd(A_CBL, 32'h0000_0800);
    $display("test midreset done");
  endtask : t_midreset

  // main sequence
  initial begin
    nrst_in = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0000_0000;
    want = 8'h00;
    len_want = 4'h0;
    tx_want = 1'b0;
    fault_want = 1'b0;
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    t_reset();
    t_enables();
    t_events();
    t_masked();
    t_cable();
    t_clear();
    t_midreset();
    end_of_test();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end
endmodule : phy_event_flags_and_cable_length_tb_top
`default_nettype wire
